/* File: shared/vic_pkg.sv */
// How it works
// R1: up to 32 level-sensitive request inputs
// R2: implemented input count is parameter; rest silent
// R3: output stream is valid plus 45-bit word
// R4: output always valid, no back-pressure accepted
// R5: word: address 44:13, set 12:7, flag 6, level 5:0
// R6: optional chain input, same word format
// R7: register port with fixed read and write timing
// R8: pending from request pin or software trigger
// R9: largest programmed level wins
// R10: level tie goes to lowest index
// R11: per-input level; zero level never wins
// R12: level width is a build parameter
// R13: per-input register set forwarded with winner
// R14: per-input nonmaskable flag forwarded with winner
// R15: address is index times spacing plus base
// R16: single clock, all state reset
// R17: chain input arbitrates; winning chain passes unchanged
// R18: disabled inputs never considered by arbitration
// R19: no request drives zero level out
package vic_pkg;

  localparam int MAX_IRQ     = 32;
  localparam int IDX_W       = 5;
  localparam int WORD_W      = 45;
  localparam int FIELD_W     = 6;
  localparam int CFG_W       = 13;
  localparam int DATA_W      = 32;
  localparam int ADDR_W      = 8;

  // stream word and config word share the low field layout
  localparam int HA_LSB      = 13;
  localparam int RS_LSB      = 7;
  localparam int NMI_BIT     = 6;
  localparam int LVL_LSB     = 0;

  // register indices; byte address is four times the index
  localparam int IDX_CONFIG0 = 0;
  localparam int IDX_ENABLE  = 32;
  localparam int IDX_EN_SET  = 33;
  localparam int IDX_EN_CLR  = 34;
  localparam int IDX_PENDING = 35;
  localparam int IDX_SW_TRIG = 36;
  localparam int IDX_VBASE   = 37;
  localparam int IDX_SPACING = 38;
  localparam int IDX_STATUS  = 39;

  localparam logic [DATA_W-1:0] RST_WORD    = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_SPACING = 32'h0000_0000;
  localparam logic [CFG_W-1:0]  RST_CFG     = 13'h0000;
  localparam logic [WORD_W-1:0] RST_STREAM  = 45'h0000_0000_0000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic [5:0] reg_index(input logic [ADDR_W-1:0] addr);
    return addr[ADDR_W-1:2];
  endfunction

endpackage

/* File: shared/arb_if.sv */
interface arb_if #(
  parameter int NUM_IRQ = 32,
  parameter int LEVEL_W = 6
);
  logic [NUM_IRQ-1:0]         req;
  logic [NUM_IRQ*LEVEL_W-1:0] levels;
  logic [vic_pkg::IDX_W-1:0]  win_idx;
  logic [LEVEL_W-1:0]         win_lvl;

  modport ctrl (output req, output levels, input win_idx, input win_lvl);
  modport arb  (input req, input levels, output win_idx, output win_lvl);
endinterface

/* File: src/vic_arbiter.sv */
module vic_arbiter #(
  parameter int NUM_IRQ = 32,
  parameter int LEVEL_W = 6
) (
  arb_if.arb bus
);

  function automatic logic [LEVEL_W-1:0] level_of(input int i);
    return bus.levels[i*LEVEL_W +: LEVEL_W];
  endfunction

  function automatic logic [vic_pkg::IDX_W-1:0] idx_cast(input int i);
    return i[vic_pkg::IDX_W-1:0];
  endfunction

  // descending scan with >= leaves the lowest index on a tie
  always_comb begin
    bus.win_idx = '0;
    bus.win_lvl = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (bus.req[i] && level_of(i) != '0 && level_of(i) >= bus.win_lvl) begin // see R9 R10 R11
        bus.win_idx = idx_cast(i);
        bus.win_lvl = level_of(i);
      end
    end
  end

endmodule

/* File: src/vector_int_ctrl.sv */
module vector_int_ctrl #(
  parameter int NUM_IRQ  = 32,
  parameter int LEVEL_W  = 6,
  parameter bit CHAIN_EN = 1'b0
) (
  // clock and reset
  input  wire logic                         SYS_CLK_I,
  input  wire logic                         RST_I,
  // interrupt request pins
  input  wire logic [vic_pkg::MAX_IRQ-1:0]  IRQ_I,
  // chain input from the upstream controller
  input  wire logic                         CHAIN_VALID_I,
  input  wire logic [vic_pkg::WORD_W-1:0]   CHAIN_DATA_I,
  // stream output to the processor or next controller
  output logic                              OUT_VALID_O,
  output logic [vic_pkg::WORD_W-1:0]        OUT_DATA_O,
  // axi4-lite write address
  input  wire logic                         AWVALID_I,
  output logic                              AWREADY_O,
  input  wire logic [vic_pkg::ADDR_W-1:0]   AWADDR_I,
  input  wire logic [2:0]                   AWPROT_I,
  // axi4-lite write data
  input  wire logic                         WVALID_I,
  output logic                              WREADY_O,
  input  wire logic [vic_pkg::DATA_W-1:0]   WDATA_I,
  input  wire logic [3:0]                   WSTRB_I,
  // axi4-lite write response
  output logic                              BVALID_O,
  input  wire logic                         BREADY_I,
  output logic [1:0]                        BRESP_O,
  // axi4-lite read address
  input  wire logic                         ARVALID_I,
  output logic                              ARREADY_O,
  input  wire logic [vic_pkg::ADDR_W-1:0]   ARADDR_I,
  input  wire logic [2:0]                   ARPROT_I,
  // axi4-lite read data
  output logic                              RVALID_O,
  input  wire logic                         RREADY_I,
  output logic [vic_pkg::DATA_W-1:0]        RDATA_O,
  output logic [1:0]                        RRESP_O
);

  localparam int MAXN = vic_pkg::MAX_IRQ;

  // configuration state
  logic [MAXN-1:0][vic_pkg::CFG_W-1:0] cfg;
  logic [MAXN-1:0]                     enable;
  logic [MAXN-1:0]                     sw_trig;
  logic [vic_pkg::DATA_W-1:0]          vec_base;
  logic [vic_pkg::DATA_W-1:0]          spacing;

  // request path
  logic [MAXN-1:0]                     irq_meta;
  logic [MAXN-1:0]                     irq_sync;
  logic [MAXN-1:0]                     pending;
  logic                                chain_wins;
  logic [LEVEL_W-1:0]                  chain_lvl;
  logic [vic_pkg::DATA_W-1:0]          handler_address;
  logic [vic_pkg::WORD_W-1:0]          next_word;

  // bus slave state
  logic                                aw_held;
  logic [vic_pkg::ADDR_W-1:0]          aw_addr;
  logic                                w_held;
  logic [vic_pkg::DATA_W-1:0]          w_data;
  logic                                do_write;
  logic [5:0]                          wr_idx;
  logic [5:0]                          rd_idx;

  arb_if #(.NUM_IRQ(NUM_IRQ), .LEVEL_W(LEVEL_W)) arb_bus ();

  vic_arbiter #(
    .NUM_IRQ (NUM_IRQ),
    .LEVEL_W (LEVEL_W)
  ) u_arbiter (
    .bus (arb_bus.arb)
  );

  // inputs past NUM_IRQ are never implemented
  function automatic logic [MAXN-1:0] impl_mask();
    logic [MAXN-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_IRQ; i++) begin
      m[i] = 1'b1;
    end
    return m;
  endfunction

  // level bits beyond LEVEL_W are kept at zero so reads show what arbitration sees
  function automatic logic [vic_pkg::CFG_W-1:0] clean_cfg(input logic [vic_pkg::DATA_W-1:0] d);
    logic [vic_pkg::CFG_W-1:0] c;
    c = d[vic_pkg::CFG_W-1:0];
    for (int b = LEVEL_W; b < vic_pkg::FIELD_W; b++) begin
      c[vic_pkg::LVL_LSB + b] = 1'b0;
    end
    return c;
  endfunction

  function automatic logic mapped(input logic [5:0] idx);
    return (idx <= 6'(vic_pkg::IDX_STATUS));
  endfunction

  // the only asynchronous inputs are the request pins
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      irq_meta <= '0;
      irq_sync <= '0;
    end else begin
      irq_meta <= IRQ_I;
      irq_sync <= irq_meta;
    end
  end

  // level sensitive: pending follows the source, nothing is latched
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin // see R16
    if (RST_I) begin
      pending <= '0;
    end else begin
      pending <= (irq_sync | sw_trig) & enable & impl_mask(); // see R1 R2 R8 R18
    end
  end

  always_comb begin
    arb_bus.req    = pending[NUM_IRQ-1:0];
    arb_bus.levels = '0;
    for (int i = 0; i < NUM_IRQ; i++) begin
      arb_bus.levels[i*LEVEL_W +: LEVEL_W] = cfg[i][vic_pkg::LVL_LSB +: LEVEL_W]; // see R11 R12
    end
  end

  // wider upstream levels are cut to the local width
  assign chain_lvl  = CHAIN_DATA_I[vic_pkg::LVL_LSB +: LEVEL_W];
  // local request keeps a level tie against the chain
  assign chain_wins = CHAIN_EN && CHAIN_VALID_I && (chain_lvl > arb_bus.win_lvl); // see R6 R17

  assign handler_address = vic_pkg::DATA_W'(32'(arb_bus.win_idx) * spacing) + vec_base; // see R15

  always_comb begin
    next_word = vic_pkg::RST_STREAM;
    if (chain_wins) begin
      next_word = CHAIN_DATA_I; // see R17
    end else if (arb_bus.win_lvl != '0) begin
      next_word[vic_pkg::HA_LSB +: vic_pkg::DATA_W] = handler_address; // see R5
      next_word[vic_pkg::RS_LSB +: vic_pkg::FIELD_W] =
        cfg[arb_bus.win_idx][vic_pkg::RS_LSB +: vic_pkg::FIELD_W]; // see R13
      next_word[vic_pkg::NMI_BIT] = cfg[arb_bus.win_idx][vic_pkg::NMI_BIT]; // see R14
      next_word[vic_pkg::LVL_LSB +: LEVEL_W] = arb_bus.win_lvl;
    end
  end

  // the stream has no ready; the word is refreshed every cycle
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      OUT_VALID_O <= 1'b0;
      OUT_DATA_O  <= vic_pkg::RST_STREAM;
    end else begin
      OUT_VALID_O <= 1'b1; // see R3 R4
      OUT_DATA_O  <= next_word; // see R19
    end
  end

  // write address and data are taken independently and joined here
  assign do_write = aw_held && w_held && !BVALID_O;
  assign wr_idx   = vic_pkg::reg_index(aw_addr);
  assign rd_idx   = vic_pkg::reg_index(ARADDR_I);

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      aw_held   <= 1'b0;
      aw_addr   <= '0;
      AWREADY_O <= 1'b1;
    end else if (AWVALID_I && AWREADY_O) begin
      aw_held   <= 1'b1;
      aw_addr   <= AWADDR_I;
      AWREADY_O <= 1'b0;
    end else if (do_write) begin
      aw_held   <= 1'b0;
      AWREADY_O <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      w_held   <= 1'b0;
      w_data   <= vic_pkg::RST_WORD;
      WREADY_O <= 1'b1;
    end else if (WVALID_I && WREADY_O) begin
      w_held   <= 1'b1;
      w_data   <= WDATA_I;
      WREADY_O <= 1'b0;
    end else if (do_write) begin
      w_held   <= 1'b0;
      WREADY_O <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin // see R7
    if (RST_I) begin
      BVALID_O <= 1'b0;
      BRESP_O  <= vic_pkg::RESP_OKAY;
    end else if (do_write) begin
      BVALID_O <= 1'b1;
      BRESP_O  <= mapped(wr_idx) ? vic_pkg::RESP_OKAY : vic_pkg::RESP_SLVERR;
    end else if (BVALID_O && BREADY_I) begin
      BVALID_O <= 1'b0;
    end
  end

  // per-input configuration; unimplemented slots ignore writes
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      for (int i = 0; i < MAXN; i++) begin
        cfg[i] <= vic_pkg::RST_CFG;
      end
    end else if (do_write && wr_idx < 6'(vic_pkg::IDX_CONFIG0 + NUM_IRQ)) begin
      cfg[wr_idx[vic_pkg::IDX_W-1:0]] <= clean_cfg(w_data); // see R11 R13 R14 R2
    end
  end

  // enable has a direct, a set and a clear view
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      enable <= vic_pkg::RST_WORD;
    end else if (do_write) begin
      unique case (wr_idx)
        6'(vic_pkg::IDX_ENABLE): begin
          enable <= w_data & impl_mask(); // see R18
        end
        6'(vic_pkg::IDX_EN_SET): begin
          enable <= enable | (w_data & impl_mask());
        end
        6'(vic_pkg::IDX_EN_CLR): begin
          enable <= enable & ~w_data;
        end
        default: begin
          enable <= enable;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sw_trig <= vic_pkg::RST_WORD;
    end else if (do_write && wr_idx == 6'(vic_pkg::IDX_SW_TRIG)) begin
      sw_trig <= w_data & impl_mask(); // see R8
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      vec_base <= vic_pkg::RST_WORD;
      spacing  <= vic_pkg::RST_SPACING;
    end else if (do_write) begin
      if (wr_idx == 6'(vic_pkg::IDX_VBASE)) begin
        vec_base <= w_data;
      end
      if (wr_idx == 6'(vic_pkg::IDX_SPACING)) begin
        spacing <= w_data;
      end
    end
  end

  function automatic logic [vic_pkg::DATA_W-1:0] read_value(input logic [5:0] idx);
    logic [vic_pkg::DATA_W-1:0] v;
    v = vic_pkg::RST_WORD;
    if (idx < 6'(vic_pkg::IDX_CONFIG0 + NUM_IRQ)) begin
      v[vic_pkg::CFG_W-1:0] = cfg[idx[vic_pkg::IDX_W-1:0]];
    end else if (idx == 6'(vic_pkg::IDX_ENABLE)) begin
      v = enable;
    end else if (idx == 6'(vic_pkg::IDX_PENDING)) begin
      v = pending;
    end else if (idx == 6'(vic_pkg::IDX_SW_TRIG)) begin
      v = sw_trig;
    end else if (idx == 6'(vic_pkg::IDX_VBASE)) begin
      v = vec_base;
    end else if (idx == 6'(vic_pkg::IDX_SPACING)) begin
      v = spacing;
    end else if (idx == 6'(vic_pkg::IDX_STATUS)) begin
      // low word of the stream: level, flag, set, plus chain winner in bit 31
      v[vic_pkg::HA_LSB-1:0] = OUT_DATA_O[vic_pkg::HA_LSB-1:0];
      v[vic_pkg::DATA_W-1]   = chain_wins;
    end
    return v;
  endfunction

  // one read at a time: the address channel closes until the data is taken
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin // see R7
    if (RST_I) begin
      ARREADY_O <= 1'b1;
      RVALID_O  <= 1'b0;
      RDATA_O   <= vic_pkg::RST_WORD;
      RRESP_O   <= vic_pkg::RESP_OKAY;
    end else if (ARVALID_I && ARREADY_O) begin
      ARREADY_O <= 1'b0;
      RVALID_O  <= 1'b1;
      RDATA_O   <= read_value(rd_idx);
      RRESP_O   <= mapped(rd_idx) ? vic_pkg::RESP_OKAY : vic_pkg::RESP_SLVERR;
    end else if (RVALID_O && RREADY_I) begin
      ARREADY_O <= 1'b1;
      RVALID_O  <= 1'b0;
    end
  end

endmodule

/* File: verification/vector_int_ctrl_checker.sv */
module vector_int_ctrl_checker (
  // clock and reset
  input wire logic        SYS_CLK_I,
  input wire logic        RST_I,
  // stream output
  input wire logic        OUT_VALID_O,
  input wire logic [44:0] OUT_DATA_O,
  // register bus
  input wire logic        AWVALID_I,
  input wire logic        AWREADY_O,
  input wire logic        WVALID_I,
  input wire logic        WREADY_O,
  input wire logic        BVALID_O,
  input wire logic        BREADY_I,
  input wire logic [1:0]  BRESP_O,
  input wire logic        ARVALID_I,
  input wire logic        ARREADY_O,
  input wire logic        RVALID_O,
  input wire logic        RREADY_I,
  input wire logic [31:0] RDATA_O
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  sequence s_wr_take;
    AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
  endsequence
  // ready stays low for one cycle and rises again together with the write response
  sequence s_wr_done;
    !AWREADY_O && !BVALID_O ##1 AWREADY_O && BVALID_O;
  endsequence
  sequence s_rd_take;
    ARVALID_I && ARREADY_O;
  endsequence
  AST_VALID: assert property (!$past(RST_I) |-> OUT_VALID_O)
    else $error("stream valid low");
  AST_IDLE_ZERO: assert property (OUT_DATA_O[5:0] == 6'h00 |-> OUT_DATA_O == 45'h0)
    else $error("idle word not zero");
  AST_WR: assert property (s_wr_take |=> s_wr_done)
    else $error("write timing");
  AST_RD: assert property (s_rd_take |=> RVALID_O && !ARREADY_O)
    else $error("read timing");
  AST_R_HOLD: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
    else $error("read data not held");
  AST_B_HOLD: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
    else $error("write response not held");
  AST_R_DONE: assert property (RVALID_O && RREADY_I |=> !RVALID_O && ARREADY_O)
    else $error("read not released");
  AST_B_DONE: assert property (BVALID_O && BREADY_I |=> !BVALID_O)
    else $error("write response not released");
endmodule

/* File: verification/vic_irq_sink.sv */
module vic_irq_sink (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // stream from the controller
  input  wire logic        valid_i,
  input  wire logic [44:0] data_i,
  // last word taken
  output logic [31:0]      handler_address_o,
  output logic [12:0]      low_fields_o
);
  // there is no ready, so a word is taken at every edge it is valid
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      handler_address_o <= 32'h0000_0000;
      low_fields_o      <= 13'h0000;
    end else if (valid_i) begin
      handler_address_o <= data_i[44:13];
      low_fields_o      <= data_i[12:0];
    end
  end
endmodule

/* File: verification/vector_int_ctrl_tb.sv */
module vector_int_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          N   = 20;
  localparam logic [31:0] MSK = 32'h000F_FFFF;
  logic        SYS_CLK_I, RST_I, CHAIN_VALID_I, OUT_VALID_O, AWVALID_I, AWREADY_O, WVALID_I, WREADY_O;
  logic        BVALID_O, BREADY_I, ARVALID_I, ARREADY_O, RVALID_O, RREADY_I;
  logic [1:0]  BRESP_O, RRESP_O;
  logic [2:0]  AWPROT_I, ARPROT_I;
  logic [3:0]  WSTRB_I;
  logic [7:0]  AWADDR_I, ARADDR_I;
  logic [31:0] IRQ_I, WDATA_I, RDATA_O, ha, seed, base, spc, en, sw, irq, x;
  logic [44:0] OUT_DATA_O, CHAIN_DATA_I;
  logic [12:0] low;
  logic [12:0] cfg [32];
  int          bad_count, checks, cycles;

  vector_int_ctrl #(.NUM_IRQ(N), .LEVEL_W(6), .CHAIN_EN(1'b1)) u_vector_int_ctrl (
    .SYS_CLK_I, .RST_I, .IRQ_I, .CHAIN_VALID_I, .CHAIN_DATA_I, .OUT_VALID_O, .OUT_DATA_O,
    .AWVALID_I, .AWREADY_O, .AWADDR_I, .AWPROT_I, .WVALID_I, .WREADY_O, .WDATA_I, .WSTRB_I,
    .BVALID_O, .BREADY_I, .BRESP_O, .ARVALID_I, .ARREADY_O, .ARADDR_I, .ARPROT_I,
    .RVALID_O, .RREADY_I, .RDATA_O, .RRESP_O);
  vic_irq_sink u_vic_irq_sink (.clk_i(SYS_CLK_I), .rst_i(RST_I), .valid_i(OUT_VALID_O),
    .data_i(OUT_DATA_O), .handler_address_o(ha), .low_fields_o(low));

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [44:0] want(input logic [31:0] pins, input logic cv, input logic [44:0] cd);
    logic [5:0]  best;
    logic [31:0] p;
    int          idx;
    best = 6'h00;
    idx = 0;
    p = (pins | sw) & en;
    for (int i = 0; i < N; i++)
      if (p[i] && cfg[i][5:0] > best) begin
        best = cfg[i][5:0];
        idx = i;
      end
    // a tie with the chain goes to the local request
    if (cv && cd[5:0] > best) return cd;
    if (best == 6'h00) return 45'h0;
    return {32'(idx) * spc + base, cfg[idx]};
  endfunction

  task automatic chk(input logic [44:0] seen, input logic [44:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input int idx, input logic [31:0] d);
    logic aw_go, w_go;
    AWADDR_I  <= 8'(idx * 4);
    WDATA_I   <= d;
    AWVALID_I <= 1'b1;
    WVALID_I  <= 1'b1;
    BREADY_I  <= 1'b1;
    aw_go = 1'b1;
    w_go = 1'b1;
    while (aw_go || w_go) begin
      @(posedge SYS_CLK_I);
      aw_go = aw_go && !AWREADY_O;
      w_go = w_go && !WREADY_O;
      AWVALID_I <= aw_go;
      WVALID_I  <= w_go;
    end
    do @(posedge SYS_CLK_I); while (!BVALID_O);
    BREADY_I <= 1'b0;
  endtask

  task automatic rd(input int idx, input logic [31:0] exp, input logic [1:0] resp);
    ARADDR_I  <= 8'(idx * 4);
    ARVALID_I <= 1'b1;
    RREADY_I  <= 1'b1;
    do @(posedge SYS_CLK_I); while (!ARREADY_O);
    ARVALID_I <= 1'b0;
    do @(posedge SYS_CLK_I); while (!RVALID_O);
    chk({11'h0, RRESP_O, RDATA_O}, {11'h0, resp, exp});
    RREADY_I <= 1'b0;
  endtask

  task automatic conclude();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always #2 SYS_CLK_I = ~SYS_CLK_I;

  // the whole sequence needs about 830 cycles
  always @(posedge SYS_CLK_I) begin
    cycles++;
    if (cycles == 8000) begin
      bad_count++;
      conclude();
    end
  end

  initial begin
    SYS_CLK_I = 1'b0;
    RST_I = 1'b1;
    seed = 32'h0000_05F5;
    {AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I, CHAIN_VALID_I} = 6'h00;
    {AWADDR_I, ARADDR_I, WDATA_I, IRQ_I, CHAIN_DATA_I} = '0;
    {AWPROT_I, ARPROT_I, WSTRB_I} = 10'h00F;
    {en, sw} = 64'h0;
    repeat (4) @(posedge SYS_CLK_I);
    RST_I <= 1'b0;
    rd(vic_pkg::IDX_ENABLE, 32'h0, vic_pkg::RESP_OKAY);
    rd(vic_pkg::IDX_SPACING, 32'h0, vic_pkg::RESP_OKAY);
    rd(41, 32'h0, vic_pkg::RESP_SLVERR);
    base = rnd();
    spc = rnd() & 32'h0000_00FC;
    wr(vic_pkg::IDX_VBASE, base);
    wr(vic_pkg::IDX_SPACING, spc);
    for (int i = 0; i < 32; i++) begin
      // levels kept to 0..3 so ties and zero levels come up often
      cfg[i] = 13'(rnd()) & 13'h1FC3;
      wr(i, {19'h0, cfg[i]});
      rd(i, i < N ? {19'h0, cfg[i]} : 32'h0, vic_pkg::RESP_OKAY);
    end
    for (int k = 0; k < 60; k++) begin
      if (k % 10 == 0) begin
        x = rnd();
        wr(vic_pkg::IDX_EN_CLR, x);
        en = en & ~x;
        x = rnd();
        wr(vic_pkg::IDX_EN_SET, x);
        en = en | x;
        sw = rnd() & rnd();
        wr(vic_pkg::IDX_SW_TRIG, sw);
      end
      // with the pins quiet only software can raise a request
      irq = (k % 10 == 5) ? 32'h0 : rnd();
      x = rnd();
      IRQ_I <= irq;
      CHAIN_VALID_I <= x[31];
      CHAIN_DATA_I <= {rnd(), 13'(x) & 13'h1FC7};
      repeat (8) @(posedge SYS_CLK_I);
      chk({ha, low}, want(irq, CHAIN_VALID_I, CHAIN_DATA_I));
      rd(vic_pkg::IDX_PENDING, (irq | sw) & en & MSK, vic_pkg::RESP_OKAY);
    end
    conclude();
  end
endmodule

bind vector_int_ctrl vector_int_ctrl_checker u_vector_int_ctrl_checker (
  .SYS_CLK_I, .RST_I, .OUT_VALID_O, .OUT_DATA_O, .AWVALID_I, .AWREADY_O, .WVALID_I, .WREADY_O,
  .BVALID_O, .BREADY_I, .BRESP_O, .ARVALID_I, .ARREADY_O, .RVALID_O, .RREADY_I, .RDATA_O);
